/* rtl/smu_pkg.sv */
// Constants and carrier types for the segment map unit
// Operation
// R1 - Sixteen segment registers, zero to fifteen, each describing one segment.
// R2 - Top four address bits pick the register; low 28 bits are the offset.
// R3 - Bit 15 set marks the segment identifier valid; unit then responds.
// R4 - I/O-channel inhibit flag set denies channel access; clear permits it.
// R5 - Processor inhibit flag set denies processor access; clear permits it.
// R6 - Bits 18 to 29 hold the 12-bit identifier forming the virtual address.
// R7 - Bits 0 to 14, 30 and 31 reserved; translation ignores them.
// R8 - Segments are linear, built of 2K pages, bounded by the 28-bit offset.
// R9 - Register fifteen always routes to the I/O bus, not paged memory.
// R10 - F000 0000 16MB is bus I/O space; following 48MB reserved.
// R11 - F400 0000 to F4FF FFFF is bus memory space.
// R12 - Four 16MB windows from FC00 0000: assist, non-assist, FP DMA, FP option.
// R13 - Register fourteen translates references from I/O-bus masters.
// R14 - Register fifteen accesses limited to supervisor state.
// R15 - Processor loads registers by I/O instructions and saves them itself.
// R16 - Channel inhibit at bit 16, processor inhibit at bit 17; bit 0 is MSB.
// R17 - Invalid entry or applicable inhibit set: no translation, access exception.
// R18 - After reset every segment register reads zero.
package smu_pkg;
  localparam int          SMU_NUM_SEG   = 16;
  localparam int          SMU_SEL_W     = 4;
  localparam int          SMU_OFF_W     = 28;
  localparam int          SMU_ID_W      = 12;
  localparam int          SMU_VA_W      = SMU_ID_W + SMU_OFF_W;
  localparam int          SMU_PAGE_W    = 11;
  // Field positions in little-endian terms; bit 0 of the map is bit 31 here
  localparam int          SMU_V_POS     = 16;
  localparam int          SMU_I_POS     = 15;
  localparam int          SMU_P_POS     = 14;
  localparam int          SMU_ID_HI     = 13;
  localparam int          SMU_ID_LO     = 2;
  localparam logic [31:0] SMU_WR_MASK   = 32'h0001_FFFC;
  localparam logic [31:0] SMU_ENTRY_RST = 32'h0000_0000;
  localparam logic [3:0]  SMU_IO_SEG    = 4'hF;
  localparam logic [3:0]  SMU_IN_SEG    = 4'hE;
  // Window select is offset bits 27..24 inside segment fifteen
  localparam logic [3:0]  SMU_WIN_BUSIO = 4'h0;
  localparam logic [3:0]  SMU_WIN_BUSMEM= 4'h4;
  localparam logic [3:0]  SMU_WIN_CPAS  = 4'hC;
  localparam logic [3:0]  SMU_WIN_CPNA  = 4'hD;
  localparam logic [3:0]  SMU_WIN_FPDMA = 4'hE;
  localparam logic [3:0]  SMU_WIN_FPOPT = 4'hF;

  typedef enum logic {
    SMU_SRC_CPU  = 1'b0,
    SMU_SRC_IOCH = 1'b1
  } smu_src_t;

  typedef enum logic [2:0] {
    SMU_W_NONE   = 3'b000,
    SMU_W_BUSIO  = 3'b001,
    SMU_W_BUSMEM = 3'b010,
    SMU_W_CPAS   = 3'b011,
    SMU_W_CPNA   = 3'b100,
    SMU_W_FPDMA  = 3'b101,
    SMU_W_FPOPT  = 3'b110,
    SMU_W_RSVD   = 3'b111
  } smu_win_t;

  typedef enum logic [1:0] {
    SMU_C_NONE    = 2'b00,
    SMU_C_INVALID = 2'b01,
    SMU_C_INHIBIT = 2'b10,
    SMU_C_PRIV    = 2'b11
  } smu_cause_t;

  typedef struct packed {
    logic        valid;
    smu_src_t    src;
    logic        supv;
    logic [31:0] ea;
  } smu_xreq_t;

  typedef struct packed {
    logic                done;
    logic                fault;
    smu_cause_t          cause;
    logic                to_iobus;
    smu_win_t            win;
    logic [SMU_VA_W-1:0] vaddr;
  } smu_xrsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  idx;
    logic [31:0] wdata;
  } smu_rreq_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } smu_rrsp_t;
endpackage

/* rtl/smu_window_dec.sv */
// Window decoder for the I/O-bus segment
`timescale 1ns/1ps
module smu_window_dec
  import smu_pkg::*;
(
  input  wire logic [3:0] hi_in,
  input  wire logic       io_seg_in,
  output smu_win_t        win_out
);
  always_comb begin
    if (!io_seg_in) begin
      win_out = SMU_W_NONE;
    end else begin
      case (hi_in)
        SMU_WIN_BUSIO:  win_out = SMU_W_BUSIO;   // [R10]
        SMU_WIN_BUSMEM: win_out = SMU_W_BUSMEM;  // [R11]
        SMU_WIN_CPAS:   win_out = SMU_W_CPAS;    // [R12]
        SMU_WIN_CPNA:   win_out = SMU_W_CPNA;    // [R12]
        SMU_WIN_FPDMA:  win_out = SMU_W_FPDMA;   // [R12]
        SMU_WIN_FPOPT:  win_out = SMU_W_FPOPT;   // [R12]
        default:        win_out = SMU_W_RSVD;    // [R10]
      endcase
    end
  end
endmodule // smu_window_dec

/* rtl/smu_access_chk.sv */
// Access check of one segment entry against the requester
`timescale 1ns/1ps
module smu_access_chk
  import smu_pkg::*;
(
  input  wire logic [31:0] entry_in,
  input  smu_src_t         src_in,
  input  wire logic        supv_in,
  input  wire logic        io_seg_in,
  input  smu_win_t         win_in,
  output logic             fault_out,
  output smu_cause_t       cause_out
);
  // Priority: invalid, then inhibit, then privilege or reserved window
  always_comb begin
    cause_out = SMU_C_NONE;
    if (!entry_in[SMU_V_POS]) begin
      cause_out = SMU_C_INVALID;                                 // [R3] [R17]
    end else if (src_in == SMU_SRC_IOCH && entry_in[SMU_I_POS]) begin
      cause_out = SMU_C_INHIBIT;                                 // [R4] [R16] [R17]
    end else if (src_in == SMU_SRC_CPU && entry_in[SMU_P_POS]) begin
      cause_out = SMU_C_INHIBIT;                                 // [R5] [R16] [R17]
    end else if (io_seg_in && (!supv_in || win_in == SMU_W_RSVD)) begin
      cause_out = SMU_C_PRIV;                                    // [R14] [R10]
    end
    fault_out = (cause_out != SMU_C_NONE);
  end
endmodule // smu_access_chk

/* rtl/smu_top.sv */
// Segment map unit: register file, translation and I/O-bus window decode
`timescale 1ns/1ps
module smu_top
  import smu_pkg::*;
#(
  parameter int NUM_SEG = SMU_NUM_SEG,
  parameter int ID_W    = SMU_ID_W
)(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  smu_xreq_t xreq_in,
  input  smu_rreq_t rreq_in,
  output smu_xrsp_t xrsp_out,
  output smu_rrsp_t rrsp_out
);
  // The select field and field layout are fixed, so other sizes cannot be served
  if (NUM_SEG != SMU_NUM_SEG || ID_W != SMU_ID_W) begin : g_bad_cfg
    $error("smu_top: NUM_SEG must be 16 and ID_W must be 12");
  end

  // Register file state
  logic [31:0] seg_r   [NUM_SEG];
  logic [31:0] seg_nxt [NUM_SEG];
  smu_rrsp_t   rrsp_r;
  smu_rrsp_t   rrsp_nxt;

  // Translation state
  smu_xrsp_t   xrsp_r;
  smu_xrsp_t   xrsp_nxt;

  // Lookup path
  logic [3:0]  sel;
  logic        io_seg;
  logic [31:0] sel_ent;
  smu_win_t    win;
  logic        chk_fault;
  smu_cause_t  chk_cause;

  // Reserved bits are dropped on write so a read never echoes them
  always_comb begin
    for (int i = 0; i < NUM_SEG; i++) begin
      seg_nxt[i] = seg_r[i];
    end
    if (rreq_in.valid && rreq_in.write) begin
      seg_nxt[rreq_in.idx] = rreq_in.wdata & SMU_WR_MASK;       // [R7] [R15]
    end
    rrsp_nxt.valid = rreq_in.valid && !rreq_in.write;
    rrsp_nxt.rdata = rreq_in.valid && !rreq_in.write ? seg_r[rreq_in.idx] : 32'h0000_0000;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_SEG; i++) begin
        seg_r[i] <= SMU_ENTRY_RST;                               // [R18] [R1]
      end
      rrsp_r <= '0;
    end else begin
      for (int i = 0; i < NUM_SEG; i++) begin
        seg_r[i] <= seg_nxt[i];                                  // [R1]
      end
      rrsp_r <= rrsp_nxt;
    end
  end

  // Channel masters arrive with a bus address only, so they always use entry 14
  always_comb begin
    if (xreq_in.src == SMU_SRC_IOCH) begin
      sel = SMU_IN_SEG;                                          // [R13]
    end else begin
      sel = xreq_in.ea[31:32-SMU_SEL_W];                         // [R2]
    end
    io_seg  = (xreq_in.src == SMU_SRC_CPU) && (sel == SMU_IO_SEG); // [R9]
    sel_ent = seg_r[sel];
  end

  smu_window_dec u_win (
    .hi_in     (xreq_in.ea[SMU_OFF_W-1:SMU_OFF_W-4]),
    .io_seg_in (io_seg),
    .win_out   (win)
  );

  smu_access_chk u_chk (
    .entry_in  (sel_ent),
    .src_in    (xreq_in.src),
    .supv_in   (xreq_in.supv),
    .io_seg_in (io_seg),
    .win_in    (win),
    .fault_out (chk_fault),
    .cause_out (chk_cause)
  );

  // A faulting request returns a zero address so nothing downstream is translated
  always_comb begin
    xrsp_nxt          = '0;
    xrsp_nxt.done     = xreq_in.valid;
    if (xreq_in.valid) begin
      xrsp_nxt.fault    = chk_fault;                             // [R17]
      xrsp_nxt.cause    = chk_cause;
      xrsp_nxt.to_iobus = io_seg && !chk_fault;                  // [R9]
      xrsp_nxt.win      = win;
      if (!chk_fault) begin
        // Whole 28-bit offset passes; page is offset[27:11], byte is offset[10:0]
        xrsp_nxt.vaddr = {sel_ent[SMU_ID_HI:SMU_ID_LO], xreq_in.ea[SMU_OFF_W-1:0]}; // [R6] [R8] [R2]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xrsp_r <= '0;
    end else begin
      xrsp_r <= xrsp_nxt;
    end
  end

  assign xrsp_out = xrsp_r;
  assign rrsp_out = rrsp_r;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_reset_clears: assert property (@(posedge clk_in) disable iff (1'b0) // [R18]
    rst_in |=> (seg_r[0] == 32'h0000_0000 && seg_r[14] == 32'h0000_0000 && seg_r[15] == 32'h0000_0000))
    else $error("segment registers not cleared by reset");

  a_rsp_one_cycle: assert property ( // [R2]
    xreq_in.valid |=> xrsp_out.done ##1 (xrsp_out.done == $past(xreq_in.valid)))
    else $error("translation answer not one cycle after request");

  a_invalid_faults: assert property ( // [R3]
    (xreq_in.valid && !sel_ent[SMU_V_POS]) |=> (xrsp_out.fault && xrsp_out.cause == SMU_C_INVALID))
    else $error("invalid segment did not fault");

  a_cpu_inhibit: assert property ( // [R5]
    (xreq_in.valid && xreq_in.src == SMU_SRC_CPU && sel_ent[SMU_V_POS] && sel_ent[SMU_P_POS])
      |=> (xrsp_out.cause == SMU_C_INHIBIT && xrsp_out.vaddr == '0))
    else $error("processor inhibit not honoured");

  a_ioch_inhibit: assert property ( // [R4]
    (xreq_in.valid && xreq_in.src == SMU_SRC_IOCH && seg_r[14][SMU_V_POS])
      |=> (xrsp_out.fault == $past(seg_r[14][SMU_I_POS])))
    else $error("channel inhibit not honoured through entry 14");

  a_segid_map: assert property ( // [R6]
    (xreq_in.valid && !chk_fault)
      |=> (xrsp_out.vaddr == {$past(sel_ent[SMU_ID_HI:SMU_ID_LO]), $past(xreq_in.ea[SMU_OFF_W-1:0])}))
    else $error("virtual address not formed from identifier and offset");

  a_seg15_route: assert property ( // [R9]
    (xreq_in.valid && xreq_in.src == SMU_SRC_CPU && xreq_in.ea[31:28] == SMU_IO_SEG && !chk_fault)
      |=> xrsp_out.to_iobus)
    else $error("segment fifteen not routed to the I/O bus");

  a_problem_state: assert property ( // [R14]
    (xreq_in.valid && io_seg && !xreq_in.supv && sel_ent[SMU_V_POS] && !sel_ent[SMU_P_POS])
      |=> (xrsp_out.cause == SMU_C_PRIV && !xrsp_out.to_iobus))
    else $error("problem-state access to I/O bus allowed");

  a_busmem_win: assert property ( // [R11]
    (xreq_in.valid && io_seg && xreq_in.ea[27:24] == SMU_WIN_BUSMEM) |=> (xrsp_out.win == SMU_W_BUSMEM))
    else $error("bus memory window misdecoded");

  a_read_back: assert property ( // [R7]
    (rreq_in.valid && rreq_in.write) ##1 (rreq_in.valid && !rreq_in.write && rreq_in.idx == $past(rreq_in.idx))
      |=> (rrsp_out.valid && rrsp_out.rdata == ($past(rreq_in.wdata, 2) & SMU_WR_MASK)))
    else $error("register read-back mismatch or reserved bits kept");
endmodule // smu_top

/* verif/smu_master_model.sv */
// Processor and I/O-channel bus master model driving the segment map unit
`timescale 1ns/1ps
module smu_master_model
  import smu_pkg::*;
(
  input  wire logic clk_in,
  input  smu_xrsp_t xrsp_in,
  input  smu_rrsp_t rrsp_in,
  output smu_xreq_t xreq_out,
  output smu_rreq_t rreq_out
);
  initial begin
    xreq_out = '0;
    rreq_out = '0;
  end

  // Entries are loaded and saved only by explicit register accesses
  task automatic reg_wr(input logic [3:0] idx, input logic [31:0] v);
    @(posedge clk_in);
    rreq_out <= '{1'b1, 1'b1, idx, v};
    @(posedge clk_in);
    rreq_out <= '{1'b0, 1'b0, ~idx, ~v};
  endtask

  // Write then read the same entry back to back; the read must see the new value
  task automatic reg_wr_rd(input logic [3:0] idx, input logic [31:0] v, output logic [31:0] rv);
    @(posedge clk_in);
    rreq_out <= '{1'b1, 1'b1, idx, v};
    @(posedge clk_in);
    rreq_out <= '{1'b1, 1'b0, idx, 32'h0000_0000};
    @(posedge clk_in);
    rreq_out <= '{1'b0, 1'b1, ~idx, 32'hFFFF_FFFF};
    @(negedge clk_in);
    rv = rrsp_in.valid ? rrsp_in.rdata : 32'hDEAD_BEEF;
  endtask

  task automatic reg_rd(input logic [3:0] idx, output logic [31:0] v);
    @(posedge clk_in);
    rreq_out <= '{1'b1, 1'b0, idx, 32'h0000_0000};
    @(posedge clk_in);
    rreq_out <= '{1'b0, 1'b1, ~idx, 32'hFFFF_FFFF};
    @(negedge clk_in);
    v = rrsp_in.valid ? rrsp_in.rdata : 32'hDEAD_BEEF;
  endtask

  // Supervisor flag comes with each request; problem state is offered too
  task automatic xlate(input smu_xreq_t q, output smu_xrsp_t s);
    @(posedge clk_in);
    xreq_out <= q;
    @(posedge clk_in);
    xreq_out <= '{1'b0, q.src, ~q.supv, ~q.ea};
    @(negedge clk_in);
    s = xrsp_in;
  endtask
endmodule // smu_master_model

/* verif/tb_top.sv */
// Self-checking testbench for the segment map unit
`timescale 1ns/1ps
module tb_top;
  import smu_pkg::*;
  logic        clk_in;
  logic        rst_in;
  smu_xreq_t   xreq;
  smu_rreq_t   rreq;
  smu_xrsp_t   xrsp;
  smu_rrsp_t   rrsp;
  smu_xreq_t   r;
  smu_xrsp_t   got;
  logic [31:0] ent [16];
  logic [31:0] d;
  logic [31:0] rd;
  integer      error_cnt;
  integer      checks;
  integer      cyc;
  integer      seed;
  integer      i;
  integer      w;

  smu_top u_smu_top (.clk_in(clk_in), .rst_in(rst_in), .xreq_in(xreq), .rreq_in(rreq),
                     .xrsp_out(xrsp), .rrsp_out(rrsp));
  smu_master_model u_smu_master_model (.clk_in(clk_in), .xrsp_in(xrsp), .rrsp_in(rrsp),
                                       .xreq_out(xreq), .rreq_out(rreq));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard: the full run needs under two thousand cycles
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  function automatic smu_win_t win_of(input logic [3:0] n);
    case (n)
      SMU_WIN_BUSIO:  return SMU_W_BUSIO;
      SMU_WIN_BUSMEM: return SMU_W_BUSMEM;
      SMU_WIN_CPAS:   return SMU_W_CPAS;
      SMU_WIN_CPNA:   return SMU_W_CPNA;
      SMU_WIN_FPDMA:  return SMU_W_FPDMA;
      SMU_WIN_FPOPT:  return SMU_W_FPOPT;
      default:        return SMU_W_RSVD;
    endcase
  endfunction

  function automatic smu_xrsp_t exp_x(input smu_xreq_t q);
    logic [3:0]  sel;
    logic [31:0] e;
    smu_xrsp_t   x;
    x      = '0;
    x.done = 1'b1;
    sel    = (q.src == SMU_SRC_IOCH) ? SMU_IN_SEG : q.ea[31:28];
    e      = ent[sel];
    if (!e[16]) begin
      x.fault = 1'b1;
      x.cause = SMU_C_INVALID;
    end else if (q.src == SMU_SRC_IOCH ? e[15] : e[14]) begin
      x.fault = 1'b1;
      x.cause = SMU_C_INHIBIT;
    end else if (sel == SMU_IO_SEG && (!q.supv || win_of(q.ea[27:24]) == SMU_W_RSVD)) begin
      x.fault = 1'b1;
      x.cause = SMU_C_PRIV;
    end else begin
      x.to_iobus = (sel == SMU_IO_SEG);
      x.win      = x.to_iobus ? win_of(q.ea[27:24]) : SMU_W_NONE;
      x.vaddr    = {e[13:2], q.ea[27:0]};
    end
    return x;
  endfunction

  task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Window code is left open on a fault, so it is only compared on success
  task chkx(input smu_xrsp_t e, input smu_xrsp_t g);
    checks = checks + 1;
    if ({g.done, g.fault, g.cause, g.to_iobus, g.vaddr} !== {e.done, e.fault, e.cause, e.to_iobus, e.vaddr}
        || (!e.fault && g.win !== e.win)) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH xrsp expected %h seen %h", e, g);
    end
  endtask

  task wr(input logic [3:0] idx, input logic [31:0] v);
    u_smu_master_model.reg_wr(idx, v);
    ent[idx] = v & SMU_WR_MASK;
  endtask

  task xcheck(input smu_xreq_t q);
    u_smu_master_model.xlate(q, got);
    chkx(exp_x(q), got);
  endtask

  initial begin
    error_cnt = 0;
    checks    = 0;
    cyc       = 0;
    seed      = 32'hc8ee;
    rst_in    = 1'b1;
    for (i = 0; i < 16; i++) ent[i] = 32'h0000_0000;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 16; i++) begin
      u_smu_master_model.reg_rd(i[3:0], rd);
      chk32("entry_reset", SMU_ENTRY_RST, rd);
    end
    // Random loads mixed with random translations, faults included
    repeat (300) begin
      i = $unsigned($random(seed)) % 16;
      d = $random(seed);
      u_smu_master_model.reg_wr_rd(i[3:0], d, rd);
      ent[i] = d & SMU_WR_MASK;
      chk32("entry_read", d & SMU_WR_MASK, rd);
      r.valid = 1'b1;
      r.src   = smu_src_t'(d[0]);
      r.supv  = d[1];
      r.ea    = $random(seed);
      xcheck(r);
    end
    // Every window of the I/O-bus entry, in both privilege states
    wr(4'hF, 32'h0001_0004);
    for (w = 0; w < 32; w++) begin
      r = '{1'b1, SMU_SRC_CPU, w[4], {4'hF, w[3:0], 24'h00_0010}};
      xcheck(r);
    end
    // Inbound entry under every inhibit combination, both sources
    for (w = 0; w < 4; w++) begin
      wr(4'hE, 32'h0001_2AF0 | {16'h0, w[0], w[1], 14'h0});
      r = '{1'b1, SMU_SRC_IOCH, 1'b0, $random(seed)};
      xcheck(r);
      r = '{1'b1, SMU_SRC_CPU, 1'b1, {4'hE, 28'hFFF_FFFF}};
      xcheck(r);
    end
    conclude();
  end
endmodule // tb_top
